// [sdhe_auto_err.sv]
`timescale 1ns/1ps
module sdhe_auto_err
   import sdhe_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register side
   sdhe_auto_if.auto_err a,
   // auto-command engine
   input wire logic auto_done,
   input wire logic auto_is_cmd23,
   input sdhe_pkg::sdhe_rsp_t rsp_outcome,
   input wire logic rsp_index_err,
   input wire logic rsp_endbit_err,
   input wire logic stop_not_issued,
   input wire logic xfer_started,
   input wire logic auto_stop_enable,
   input wire logic follow_skipped
);
   typedef struct packed {
      logic [7:0] stat;
      logic new_err;
   } sdhe_aerr_t;
   sdhe_aerr_t s, next_s;
   logic [3:0] rsp_bits;

   always_comb begin
      next_s = s;
      next_s.new_err = 1'b0;
      rsp_bits = {rsp_index_err, rsp_endbit_err, rsp_outcome};
      // clear first so a same-cycle event survives the read
      if (a.rd_clear) begin
         next_s.stat = SDHE_RST_AUTO;
      end
      if (auto_done) begin
         next_s.stat[SDHE_AS_INDEX:SDHE_AS_TIMEOUT] = next_s.stat[SDHE_AS_INDEX:SDHE_AS_TIMEOUT] | rsp_bits;
         if (|rsp_bits) begin
            next_s.new_err = 1'b1;
         end
         if (auto_is_cmd23) begin
            next_s.stat[SDHE_AS_FOLLOW] = 1'b0;
            next_s.stat[SDHE_AS_NOT_ISSUED] = 1'b0;
         end
      end
      // no stop is owed for a transfer that never began
      if (stop_not_issued && xfer_started && auto_stop_enable && !auto_is_cmd23) begin
         next_s.stat[SDHE_AS_NOT_ISSUED] = 1'b1;
         next_s.new_err = 1'b1;
      end
      if (follow_skipped && !auto_is_cmd23 && (|next_s.stat[SDHE_AS_INDEX:SDHE_AS_TIMEOUT])) begin
         next_s.stat[SDHE_AS_FOLLOW] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign a.status = s.stat;
   assign a.new_err = s.new_err;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_index_record: assert property (@(posedge clk) disable iff (!reset_n)
      auto_done && rsp_index_err |=> s.stat[SDHE_AS_INDEX] && s.new_err)
      else $error("index error not recorded");
   a_conflict_code: assert property (@(posedge clk) disable iff (!reset_n)
      auto_done && rsp_outcome == SDHE_RSP_CONFLICT |=> s.stat[SDHE_AS_CRC] && s.stat[SDHE_AS_TIMEOUT])
      else $error("line conflict not encoded as crc and timeout");
   a_cmd23_clean: assert property (@(posedge clk) disable iff (!reset_n)
      auto_done && auto_is_cmd23 |=> !s.stat[SDHE_AS_FOLLOW] && !s.stat[SDHE_AS_NOT_ISSUED])
      else $error("cmd23 error set stop-only bits");
   a_not_issued_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(s.stat[SDHE_AS_NOT_ISSUED]) |-> $past(stop_not_issued && xfer_started && auto_stop_enable))
      else $error("not-issued bit set without cause");
   a_follow_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(s.stat[SDHE_AS_FOLLOW]) |-> $past(follow_skipped) && (|s.stat[SDHE_AS_INDEX:SDHE_AS_TIMEOUT]))
      else $error("follow bit set without auto error");
   a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
      a.rd_clear && !auto_done && !stop_not_issued |=> s.stat == SDHE_RST_AUTO)
      else $error("status not cleared by read");
   c_conflict: cover property (@(posedge clk) disable iff (!reset_n)
      auto_done && rsp_outcome == SDHE_RSP_CONFLICT);
   c_not_issued: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(s.stat[SDHE_AS_NOT_ISSUED]));
   c_follow: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(s.stat[SDHE_AS_FOLLOW]));
endmodule : sdhe_auto_err

// [sdhe_auto_if.sv]
`timescale 1ns/1ps
interface sdhe_auto_if;
   logic rd_clear;
   logic [7:0] status;
   logic new_err;
   modport regs (output rd_clear, input status, input new_err);
   modport auto_err (input rd_clear, output status, output new_err);
endinterface : sdhe_auto_if

// [sdhe_card_model.sv]
`timescale 1ns/1ps
module sdhe_card_model
   import sdhe_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // auto-command engine side
   output logic auto_done,
   output logic auto_is_cmd23,
   output sdhe_pkg::sdhe_rsp_t rsp_outcome,
   output logic index_err,
   output logic endbit_err,
   output logic stop_not_issued,
   output logic stop_enable,
   output logic xfer_started,
   output logic follow_skipped,
   // card line
   output logic card_irq,
   output logic sd_clk_running
);
   initial begin
      {auto_done, auto_is_cmd23, index_err, endbit_err, stop_not_issued} = 5'h00;
      {stop_enable, xfer_started, follow_skipped, card_irq, sd_clk_running} = 5'h00;
      rsp_outcome = SDHE_RSP_OK;
   end
   // ----------------------------------------
   // one response, qualified by a done pulse
   // ----------------------------------------
   task automatic respond(input logic cmd23, input sdhe_rsp_t o, input logic idx, input logic eb, input logic skip);
      @(posedge clk);
      auto_done <= 1'b1;
      auto_is_cmd23 <= cmd23;
      rsp_outcome <= o;
      index_err <= idx;
      endbit_err <= eb;
      follow_skipped <= skip;
      @(posedge clk);
      auto_done <= 1'b0;
      follow_skipped <= 1'b0;
      // qualifiers are junk outside the pulse, so a design that ignores done shows it
      rsp_outcome <= sdhe_rsp_t'(~o);
      index_err <= ~idx;
      endbit_err <= ~eb;
   endtask : respond
   task automatic stop_fail(input logic started, input logic cmd23);
      @(posedge clk);
      stop_enable <= 1'b1;
      xfer_started <= started;
      auto_is_cmd23 <= cmd23;
      stop_not_issued <= 1'b1;
      @(posedge clk);
      stop_not_issued <= 1'b0;
   endtask : stop_fail
   task automatic set_card(input logic irq, input logic clk_run);
      @(posedge clk);
      card_irq <= irq;
      sd_clk_running <= clk_run;
   endtask : set_card
endmodule : sdhe_card_model

// [sdhe_pkg.sv]
package sdhe_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] SDHE_OFS_ERR_STAT = 8'h32;
   localparam logic [7:0] SDHE_OFS_ERR_STAT_EN = 8'h36;
   localparam logic [7:0] SDHE_OFS_ERR_SIG_EN = 8'h3A;
   localparam logic [7:0] SDHE_OFS_AUTO_STAT = 8'h3C;
   localparam logic [7:0] SDHE_OFS_HOST_CTL2 = 8'h3E;
   localparam logic [7:0] SDHE_OFS_CAPS_0 = 8'h40;
   localparam logic [7:0] SDHE_OFS_CAPS_1 = 8'h42;
   localparam logic [7:0] SDHE_OFS_CAPS_2 = 8'h44;
   localparam logic [7:0] SDHE_OFS_CAPS_3 = 8'h46;
   // ------------------------------------------------------------
   // writable bit masks and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] SDHE_ERR_MASK = 16'h03FF;
   localparam logic [15:0] SDHE_HC2_MASK = 16'hC000;
   localparam logic [15:0] SDHE_CAPS2_MASK = 16'h0007;
   localparam logic [15:0] SDHE_RST_ERR = 16'h0000;
   localparam logic [15:0] SDHE_RST_HC2 = 16'h0000;
   localparam logic [15:0] SDHE_RST_CAPS2 = 16'h0000;
   localparam logic [7:0] SDHE_RST_AUTO = 8'h00;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SDHE_BIT_AUTO_ERR = 8;
   localparam int SDHE_BIT_PRESET = 15;
   localparam int SDHE_BIT_ASYNC = 14;
   localparam int SDHE_AS_FOLLOW = 7;
   localparam int SDHE_AS_INDEX = 4;
   localparam int SDHE_AS_ENDBIT = 3;
   localparam int SDHE_AS_CRC = 2;
   localparam int SDHE_AS_TIMEOUT = 1;
   localparam int SDHE_AS_NOT_ISSUED = 0;
   // ------------------------------------------------------------
   // response outcome, bit 1 = crc, bit 0 = timeout
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SDHE_RSP_OK = 2'b00,
      SDHE_RSP_TIMEOUT = 2'b01,
      SDHE_RSP_CRC = 2'b10,
      SDHE_RSP_CONFLICT = 2'b11
   } sdhe_rsp_t;
endpackage : sdhe_pkg

// [sdhe_regs.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
module sdhe_regs
   import sdhe_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR_STROBE,
   input wire logic RD_STROBE,
   output logic [15:0] RDATA,
   // error sources and the normal interrupt request from the engines
   input wire logic [9:0] ERR_EVENT,
   input wire logic NORMAL_IRQ_REQ,
   // auto-command engine
   input wire logic AUTO_DONE,
   input wire logic AUTO_IS_CMD23,
   input sdhe_pkg::sdhe_rsp_t AUTO_RSP_OUTCOME,
   input wire logic AUTO_INDEX_ERR,
   input wire logic AUTO_ENDBIT_ERR,
   input wire logic AUTO_STOP_NOT_ISSUED,
   input wire logic AUTO_STOP_ENABLE,
   input wire logic MBLK_XFER_STARTED,
   input wire logic FOLLOW_CMD_SKIPPED,
   // card interrupt path
   input wire logic CARD_IRQ_IN,
   input wire logic SD_CLK_RUNNING,
   output logic CARD_IRQ_OUT,
   // to host system and clock generator
   output logic IRQ,
   output logic PRESET_SELECTION_ON,
   output logic ASYNC_CARD_IRQ_MODE
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] err_stat;
      logic [15:0] err_stat_en;
      logic [15:0] err_sig_en;
      logic [15:0] host_ctl2;
      logic [15:0] caps2;
      logic [15:0] rdata;
      logic irq;
      logic card_irq;
   } sdhe_regs_t;

   sdhe_regs_t s;
   sdhe_regs_t next_s;
   logic [15:0] err_events;
   logic wr_err_stat;
   logic wr_stat_en;
   logic wr_sig_en;
   logic wr_hc2;
   logic wr_caps2;

   sdhe_auto_if auto_bus ();

   // ------------------------------------------------------------
   // auto-command error status, for stop and cmd23 responses
   // ------------------------------------------------------------
   // a read of the status clears it on the same edge that
   // captures the read data, so nothing is lost between them
   assign auto_bus.rd_clear = RD_STROBE && (ADDR == SDHE_OFS_AUTO_STAT);

   sdhe_auto_err u_auto_err (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .a(auto_bus.auto_err),
      .auto_done(AUTO_DONE),
      .auto_is_cmd23(AUTO_IS_CMD23),
      .rsp_outcome(AUTO_RSP_OUTCOME),
      .rsp_index_err(AUTO_INDEX_ERR),
      .rsp_endbit_err(AUTO_ENDBIT_ERR),
      .stop_not_issued(AUTO_STOP_NOT_ISSUED),
      .xfer_started(MBLK_XFER_STARTED),
      .auto_stop_enable(AUTO_STOP_ENABLE),
      .follow_skipped(FOLLOW_CMD_SKIPPED)
   );

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   assign wr_err_stat = WR_STROBE && (ADDR == SDHE_OFS_ERR_STAT);
   assign wr_stat_en = WR_STROBE && (ADDR == SDHE_OFS_ERR_STAT_EN);
   assign wr_sig_en = WR_STROBE && (ADDR == SDHE_OFS_ERR_SIG_EN);
   assign wr_hc2 = WR_STROBE && (ADDR == SDHE_OFS_HOST_CTL2);
   assign wr_caps2 = WR_STROBE && (ADDR == SDHE_OFS_CAPS_2);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      err_events = {6'h00, ERR_EVENT};
      // the auto summary also rises from the status block itself
      err_events[SDHE_BIT_AUTO_ERR] = ERR_EVENT[SDHE_BIT_AUTO_ERR] | auto_bus.new_err;

      // enables, host control 2 and caps 2, reserved bits masked off
      if (wr_stat_en) begin
         next_s.err_stat_en = WDATA & SDHE_ERR_MASK;
      end
      if (wr_sig_en) begin
         next_s.err_sig_en = WDATA & SDHE_ERR_MASK;
      end
      if (wr_hc2) begin
         next_s.host_ctl2 = WDATA & SDHE_HC2_MASK;
      end
      if (wr_caps2) begin
         next_s.caps2 = WDATA & SDHE_CAPS2_MASK;
      end

      // latched errors: write one to clear, a new event wins
      if (wr_err_stat) begin
         next_s.err_stat = s.err_stat & ~WDATA;
      end
      next_s.err_stat = (next_s.err_stat | (err_events & s.err_stat_en)) & SDHE_ERR_MASK;

      // one shared line; the registered term costs a cycle of
      // latency but keeps the pin free of decode glitches
      next_s.irq = (|(s.err_stat & s.err_sig_en)) | NORMAL_IRQ_REQ;

      // card interrupt detection needs the sd clock unless the
      // asynchronous mode is on
      next_s.card_irq = CARD_IRQ_IN && (SD_CLK_RUNNING || s.host_ctl2[SDHE_BIT_ASYNC]);

      // read data stand for exactly one cycle
      next_s.rdata = 16'h0000;
      if (RD_STROBE) begin
         case (ADDR)
            SDHE_OFS_ERR_STAT: begin
               next_s.rdata = s.err_stat;
            end
            SDHE_OFS_ERR_STAT_EN: begin
               next_s.rdata = s.err_stat_en;
            end
            SDHE_OFS_ERR_SIG_EN: begin
               next_s.rdata = s.err_sig_en;
            end
            SDHE_OFS_AUTO_STAT: begin
               next_s.rdata = {8'h00, auto_bus.status};
            end
            SDHE_OFS_HOST_CTL2: begin
               next_s.rdata = s.host_ctl2;
            end
            SDHE_OFS_CAPS_2: begin
               next_s.rdata = s.caps2;
            end
            default: begin
               // unmapped and unimplemented words read zero
               next_s.rdata = 16'h0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         s.err_stat <= SDHE_RST_ERR;
         s.err_stat_en <= SDHE_RST_ERR;
         s.err_sig_en <= SDHE_RST_ERR;
         s.host_ctl2 <= SDHE_RST_HC2;
         s.caps2 <= SDHE_RST_CAPS2;
         s.rdata <= 16'h0000;
         s.irq <= 1'b0;
         s.card_irq <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign RDATA = s.rdata;
   assign IRQ = s.irq;
   assign CARD_IRQ_OUT = s.card_irq;
   assign PRESET_SELECTION_ON = s.host_ctl2[SDHE_BIT_PRESET];
   assign ASYNC_CARD_IRQ_MODE = s.host_ctl2[SDHE_BIT_ASYNC];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_auto_gate_on: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      s.err_stat[SDHE_BIT_AUTO_ERR] && s.err_sig_en[SDHE_BIT_AUTO_ERR] |=> IRQ)
      else $error("auto error enabled but line low");
   a_irq_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      ((s.err_stat & s.err_sig_en) == 16'h0000) && !NORMAL_IRQ_REQ |=> !IRQ)
      else $error("line high with no enabled error");
   a_irq_shared: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      NORMAL_IRQ_REQ || (|(s.err_stat & s.err_sig_en)) |=> IRQ)
      else $error("shared line missed a source");
   // every bit at once: a new latch needs the enable of the cycle before
   a_latch_gate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (s.err_stat & ~$past(s.err_stat) & ~$past(s.err_stat_en)) == 16'h0000)
      else $error("error latched while status enable clear");
   a_auto_summary: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      auto_bus.new_err && s.err_stat_en[SDHE_BIT_AUTO_ERR] |=> s.err_stat[SDHE_BIT_AUTO_ERR])
      else $error("auto error summary not latched");
   a_auto_read: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      RD_STROBE && ADDR == SDHE_OFS_AUTO_STAT |=> RDATA == {8'h00, $past(auto_bus.status)})
      else $error("auto status read data wrong");
   a_async_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wr_hc2 |=> ASYNC_CARD_IRQ_MODE == $past(WDATA[SDHE_BIT_ASYNC]))
      else $error("async mode not taken from write");
   a_card_gated: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !SD_CLK_RUNNING && !ASYNC_CARD_IRQ_MODE |=> !CARD_IRQ_OUT)
      else $error("card interrupt passed with clock stopped");
   for (genvar i = 0; i < 16; i++) begin : g_irq_bit
      a_irq_per_bit: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
         s.err_stat[i] && s.err_sig_en[i] |=> IRQ)
         else $error("enabled error bit left line low");
   end
   a_preset_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wr_hc2 |=> PRESET_SELECTION_ON == $past(WDATA[SDHE_BIT_PRESET]))
      else $error("preset selection not taken from write");
   a_card_forward: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      ASYNC_CARD_IRQ_MODE && CARD_IRQ_IN |=> CARD_IRQ_OUT)
      else $error("card interrupt dropped in async mode");
   a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      RD_STROBE && ADDR == SDHE_OFS_HOST_CTL2 |=> RDATA[13:0] == 14'h0000)
      else $error("reserved bits read nonzero");
   a_caps_fixed: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      RD_STROBE && ADDR == SDHE_OFS_CAPS_2 |=> RDATA[15:3] == 13'h0000)
      else $error("capability word reserved bits set");
   c_irq_auto: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(IRQ) && s.err_stat[SDHE_BIT_AUTO_ERR]);
   c_card_async: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
      CARD_IRQ_OUT && !SD_CLK_RUNNING);
endmodule : sdhe_regs

// [tb.sv]
`timescale 1ns/1ps
module tb;
   import sdhe_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [9:0] err_event = 10'h000;
   logic normal_irq = 1'b0;
   logic [15:0] rdata;
   logic done, cmd23, idx, eb, not_iss, stop_en, started, skipped, card_irq, clk_run;
   sdhe_rsp_t outcome;
   logic card_out, irq, preset_on, async_on;
   int error_cnt = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   sdhe_regs sdhe_regs_inst (.CLK_SYS(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR_STROBE(wr_s),
      .RD_STROBE(rd_s), .RDATA(rdata), .ERR_EVENT(err_event), .NORMAL_IRQ_REQ(normal_irq), .AUTO_DONE(done),
      .AUTO_IS_CMD23(cmd23), .AUTO_RSP_OUTCOME(outcome), .AUTO_INDEX_ERR(idx), .AUTO_ENDBIT_ERR(eb),
      .AUTO_STOP_NOT_ISSUED(not_iss), .AUTO_STOP_ENABLE(stop_en), .MBLK_XFER_STARTED(started),
      .FOLLOW_CMD_SKIPPED(skipped), .CARD_IRQ_IN(card_irq), .SD_CLK_RUNNING(clk_run), .CARD_IRQ_OUT(card_out),
      .IRQ(irq), .PRESET_SELECTION_ON(preset_on), .ASYNC_CARD_IRQ_MODE(async_on));
   sdhe_card_model sdhe_card_model_inst (.clk(clk), .reset_n(reset_n), .auto_done(done), .auto_is_cmd23(cmd23),
      .rsp_outcome(outcome), .index_err(idx), .endbit_err(eb), .stop_not_issued(not_iss), .stop_enable(stop_en),
      .xfer_started(started), .follow_skipped(skipped), .card_irq(card_irq), .sd_clk_running(clk_run));
   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, rdata);
   endtask : rd_chk
   task automatic pulse_err(input logic [9:0] e);
      @(posedge clk);
      err_event <= e;
      @(posedge clk);
      err_event <= 10'h000;
   endtask : pulse_err
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [7:0] offs [10] = '{8'h32, 8'h36, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50};
      foreach (offs[i]) rd_chk(offs[i], 16'h0000);
   endtask : t_reset
   task automatic t_rw;
      wr(8'h3A, 16'hFFFF);
      rd_chk(8'h3A, 16'h03FF);
      cyc(1);
      chk("rdata idle", 16'h0000, rdata);
      wr(8'h3E, 16'hFFFF);
      rd_chk(8'h3E, 16'hC000);
      chk("preset", 16'h0001, {15'h0000, preset_on});
      wr(8'h44, 16'hFFFF);
      rd_chk(8'h44, 16'h0007);
      wr(8'h46, 16'hFFFF);
      rd_chk(8'h46, 16'h0000);
      wr(8'h50, 16'hFFFF);
      rd_chk(8'h50, 16'h0000);
      wr(8'h3E, 16'h0000);
      wr(8'h3A, 16'h0000);
      cyc(2);
      chk("preset", 16'h0000, {15'h0000, preset_on});
   endtask : t_rw
   task automatic t_err;
      logic [15:0] b;
      for (int n = 0; n < 10; n++) begin
         b = 16'h0001 << n;
         wr(8'h36, b);
         pulse_err(b[9:0]);
         cyc(3);
         chk("irq off", 16'h0000, {15'h0000, irq});
         rd_chk(8'h32, b);
         wr(8'h3A, b);
         cyc(3);
         chk("irq on", 16'h0001, {15'h0000, irq});
         wr(8'h32, b);
         cyc(3);
         chk("irq clr", 16'h0000, {15'h0000, irq});
      end
      wr(8'h36, 16'h0000);
      pulse_err(10'h001);
      cyc(3);
      rd_chk(8'h32, 16'h0000);
      chk("irq idle", 16'h0000, {15'h0000, irq});
   endtask : t_err
   task automatic t_auto;
      wr(8'h36, 16'h0100);
      for (int k = 0; k < 4; k++) begin
         sdhe_card_model_inst.respond(1'b0, sdhe_rsp_t'(k), 1'b0, 1'b0, 1'b0);
         rd_chk(8'h32, (k == 0) ? 16'h0000 : 16'h0100);
         rd_chk(8'h3C, 16'(k) << 1);
         rd_chk(8'h3C, 16'h0000);
      end
      cyc(3);
      chk("auto irq gated", 16'h0000, {15'h0000, irq});
      wr(8'h3A, 16'h0100);
      cyc(3);
      chk("auto irq", 16'h0001, {15'h0000, irq});
      wr(8'h32, 16'h0100);
      wr(8'h3A, 16'h0000);
      wr(8'h36, 16'h0000);
   endtask : t_auto
   task automatic t_follow;
      sdhe_card_model_inst.respond(1'b0, SDHE_RSP_OK, 1'b1, 1'b1, 1'b1);
      rd_chk(8'h3C, 16'h0098);
      sdhe_card_model_inst.respond(1'b1, SDHE_RSP_TIMEOUT, 1'b0, 1'b0, 1'b1);
      rd_chk(8'h3C, 16'h0002);
      sdhe_card_model_inst.respond(1'b0, SDHE_RSP_OK, 1'b0, 1'b0, 1'b1);
      rd_chk(8'h3C, 16'h0000);
   endtask : t_follow
   task automatic t_stop;
      sdhe_card_model_inst.stop_fail(1'b1, 1'b0);
      rd_chk(8'h3C, 16'h0001);
      sdhe_card_model_inst.stop_fail(1'b0, 1'b0);
      rd_chk(8'h3C, 16'h0000);
      sdhe_card_model_inst.stop_fail(1'b1, 1'b1);
      rd_chk(8'h3C, 16'h0000);
   endtask : t_stop
   task automatic t_card;
      sdhe_card_model_inst.set_card(1'b1, 1'b1);
      cyc(2);
      chk("card clk", 16'h0001, {15'h0000, card_out});
      sdhe_card_model_inst.set_card(1'b1, 1'b0);
      cyc(2);
      chk("card stopped", 16'h0000, {15'h0000, card_out});
      wr(8'h3E, 16'h4000);
      cyc(2);
      chk("async mode", 16'h0001, {15'h0000, async_on});
      chk("card async", 16'h0001, {15'h0000, card_out});
      sdhe_card_model_inst.set_card(1'b0, 1'b0);
      cyc(2);
      chk("card low", 16'h0000, {15'h0000, card_out});
   endtask : t_card
   task automatic t_shared;
      @(posedge clk);
      normal_irq <= 1'b1;
      cyc(2);
      chk("shared irq", 16'h0001, {15'h0000, irq});
      @(posedge clk);
      normal_irq <= 1'b0;
      cyc(2);
      chk("shared irq off", 16'h0000, {15'h0000, irq});
   endtask : t_shared
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic summarize;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_rw();
      t_err();
      t_auto();
      t_follow();
      t_stop();
      t_card();
      t_shared();
      summarize();
   end
   // hang guard, far above the longest sequence
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end
endmodule : tb
